// *** core/monitor_command_link.v ***
// Monitor command interpreter on one wired-OR serial pin, with the ROM security gate.
// Assumes synchronous inputs, memory data valid one cycle after MEM_RD, and POR_N low only at power-on.
`timescale 1ns/1ps
`include "monitor_command_link_regs.vh"

module monitor_command_link #(
    parameter [13:0] BIT_CYCLES = `BIT_CYC
) (
    input wire SYS_CLK,
    input wire NRST,
    input wire POR_N,
    input wire DIV_SEL,
    input wire SER_IN,
    output wire SER_OUT,
    output wire SER_OE_N,
    output wire [15:0] MEM_ADDR,
    output wire MEM_RD,
    output wire MEM_WR,
    output wire [7:0] MEM_WDATA,
    input wire [7:0] MEM_RDATA,
    input wire [15:0] STACK_PTR,
    input wire FETCH_VALID,
    input wire [15:0] FETCH_ADDR,
    output wire RUN_RTI,
    output wire ILLEGAL_RST,
    output wire SEC_BYPASSED,
    output wire ROM_EXEC_EN
);

    localparam [1:0] R_IDLE = 2'h0;
    localparam [1:0] R_START = 2'h1;
    localparam [1:0] R_BITS = 2'h2;
    localparam [1:0] R_WAIT = 2'h3;

    localparam [3:0] S_SEC = 4'h0;
    localparam [3:0] S_RW = 4'h1;
    localparam [3:0] S_RG = 4'h2;
    localparam [3:0] S_READY = 4'h3;
    localparam [3:0] S_OP = 4'h4;
    localparam [3:0] S_AH = 4'h5;
    localparam [3:0] S_AL = 4'h6;
    localparam [3:0] S_DAT = 4'h7;
    localparam [3:0] S_SEND = 4'h8;

    reg [1:0] rx_st_q;
    reg [13:0] rx_cnt_q;
    reg [3:0] rx_n_q;
    reg [7:0] rx_sh_q;
    reg [11:0] tx_sh_q;
    reg [3:0] tx_n_q;
    reg [13:0] tx_cnt_q;
    reg oe_n_q;
    reg [3:0] st_q;
    reg [7:0] cmd_q;
    reg [15:0] ptr_q;
    reg [15:0] addr_q;
    reg [7:0] res_q;
    reg [7:0] rxb_q;
    reg [2:0] idx_q;
    reg mism_q, in_sec_q, second_q;
    reg [15:0] mem_addr_q;
    reg mem_rd_q, mem_wr_q;
    reg [7:0] mem_wdata_q;
    reg run_q;
    reg [1:0] sec_q;
    reg init_q, div_q, ill_q;

    wire [13:0] bit_len, half_len;
    wire tx_idle, rx_done, rx_byte_v, rx_brk_v, res_go, neq;
    wire sec_done, sec_match, rd_in_rom, fetch_in_rom, bypassed;

    // Bit period follows the divider pin caught at reset release; the slow mode doubles it.
    assign bit_len = div_q ? {BIT_CYCLES[12:0], 1'b0} : BIT_CYCLES;
    assign half_len = {1'b0, bit_len[13:1]};
    assign tx_idle = (tx_n_q == 4'h0);
    assign bypassed = (sec_q == `SEC_BYPASS);

    // Receive events; the stop sample decides between a byte and a break.
    assign rx_done = (rx_st_q == R_BITS) && (rx_cnt_q == 14'h0000) && (rx_n_q == 4'h8);
    assign rx_byte_v = rx_done && SER_IN;
    assign rx_brk_v = rx_done && !SER_IN && (rx_sh_q == 8'h00);
    // A result waits for the line to be free and yields to a fresh echo.
    assign res_go = tx_idle && !rx_done && ((st_q == S_SEND) || (st_q == S_READY));

    // Security verdict is formed on the last compared byte.
    assign neq = (MEM_RDATA != rxb_q);
    assign sec_done = (st_q == S_RG) && in_sec_q && (idx_q == `SEC_LAST_IDX);
    assign sec_match = !(mism_q || neq);
    assign rd_in_rom = (mem_addr_q >= `ROM_LO); // ROM runs to the top of the map.
    assign fetch_in_rom = (FETCH_ADDR >= `ROM_LO);

    assign SER_OUT = tx_sh_q[0];
    assign SER_OE_N = oe_n_q;
    assign MEM_ADDR = mem_addr_q;
    assign MEM_RD = mem_rd_q;
    assign MEM_WR = mem_wr_q;
    assign MEM_WDATA = mem_wdata_q;
    assign RUN_RTI = run_q;
    assign ILLEGAL_RST = ill_q;
    assign SEC_BYPASSED = bypassed;
    assign ROM_EXEC_EN = bypassed;

    // Receiver only starts a new frame while the transmitter is idle, otherwise it would hear its own echo.
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            rx_st_q <= R_IDLE;
            rx_cnt_q <= 14'h0000;
            rx_n_q <= 4'h0;
            rx_sh_q <= 8'h00;
        end else begin
            case (rx_st_q)
                R_IDLE: begin
                    if (tx_idle && !SER_IN) begin
                        rx_st_q <= R_START;
                        rx_cnt_q <= half_len;
                    end
                end
                R_START: begin
                    if (rx_cnt_q != 14'h0000) begin
                        rx_cnt_q <= rx_cnt_q - 14'h0001;
                    end else if (SER_IN) begin
                        rx_st_q <= R_IDLE;
                    end else begin
                        rx_st_q <= R_BITS;
                        rx_cnt_q <= bit_len - 14'h0001;
                        rx_n_q <= 4'h0;
                    end
                end
                R_BITS: begin
                    if (rx_cnt_q != 14'h0000) begin
                        rx_cnt_q <= rx_cnt_q - 14'h0001;
                    end else begin
                        rx_cnt_q <= bit_len - 14'h0001;
                        if (rx_n_q == 4'h8) begin
                            rx_st_q <= R_WAIT;
                        end else begin
                            rx_sh_q <= {SER_IN, rx_sh_q[7:1]};
                            rx_n_q <= rx_n_q + 4'h1;
                        end
                    end
                end
                R_WAIT: begin
                    if (SER_IN) begin
                        rx_st_q <= R_IDLE;
                    end
                end
                default: rx_st_q <= R_IDLE;
            endcase
        end
    end

    // Transmitter drives the pin both ways during a frame and releases it between frames.
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            tx_sh_q <= `FRAME_IDLE;
            tx_n_q <= 4'h0;
            tx_cnt_q <= 14'h0000;
            oe_n_q <= 1'b1;
        end else if (rx_byte_v) begin
            tx_sh_q <= {3'h7, rx_sh_q, 1'b0};
            tx_n_q <= `FRAME_LEN_BYTE;
            tx_cnt_q <= bit_len - 14'h0001;
            oe_n_q <= 1'b0;
        end else if (rx_brk_v) begin
            tx_sh_q <= `FRAME_BRK_ECHO;
            tx_n_q <= `FRAME_LEN_BRK_ECHO;
            tx_cnt_q <= bit_len - 14'h0001;
            oe_n_q <= 1'b0;
        end else if (res_go) begin
            tx_sh_q <= (st_q == S_READY) ? `FRAME_BRK_READY : {3'h7, res_q, 1'b0};
            tx_n_q <= `FRAME_LEN_BYTE;
            tx_cnt_q <= bit_len - 14'h0001;
            oe_n_q <= 1'b0;
        end else if (!tx_idle) begin
            if (tx_cnt_q != 14'h0000) begin
                tx_cnt_q <= tx_cnt_q - 14'h0001;
            end else if (tx_n_q == 4'h1) begin
                tx_n_q <= 4'h0;
                tx_sh_q <= `FRAME_IDLE;
                oe_n_q <= 1'b1;
            end else begin
                tx_sh_q <= {1'b1, tx_sh_q[11:1]};
                tx_n_q <= tx_n_q - 4'h1;
                tx_cnt_q <= bit_len - 14'h0001;
            end
        end
    end

    // Command sequencer; every reset starts in the security phase again.
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            st_q <= S_SEC;
            cmd_q <= 8'h00;
            ptr_q <= 16'h0000;
            addr_q <= 16'h0000;
            res_q <= 8'h00;
            rxb_q <= 8'h00;
            idx_q <= 3'h0;
            mism_q <= 1'b0;
            in_sec_q <= 1'b1;
            second_q <= 1'b0;
            mem_addr_q <= 16'h0000;
            mem_rd_q <= 1'b0;
            mem_wr_q <= 1'b0;
            mem_wdata_q <= 8'h00;
            run_q <= 1'b0;
        end else begin
            mem_rd_q <= 1'b0;
            mem_wr_q <= 1'b0;
            run_q <= 1'b0;
            if (rx_brk_v && !in_sec_q) begin
                st_q <= S_OP;
            end else begin
                case (st_q)
                    S_SEC: begin
                        if (rx_byte_v) begin
                            rxb_q <= rx_sh_q;
                            mem_addr_q <= `SEC_BASE + {13'h0000, idx_q};
                            mem_rd_q <= 1'b1;
                            st_q <= S_RW;
                        end
                    end
                    S_RW: st_q <= S_RG;
                    S_RG: begin
                        if (in_sec_q) begin
                            mism_q <= mism_q || neq;
                            idx_q <= idx_q + 3'h1;
                            st_q <= sec_done ? S_READY : S_SEC;
                        end else begin
                            // A locked or failed part hides ROM contents behind a fixed value.
                            res_q <= (rd_in_rom && !bypassed) ? `UNDEF_DATA : MEM_RDATA;
                            st_q <= S_SEND;
                        end
                    end
                    S_READY: begin
                        if (res_go) begin
                            in_sec_q <= 1'b0;
                            st_q <= S_OP;
                        end
                    end
                    S_OP: begin
                        if (rx_byte_v) begin
                            cmd_q <= rx_sh_q;
                            second_q <= 1'b0;
                            case (rx_sh_q)
                                `OP_WRITE, `OP_READ: st_q <= S_AH;
                                `OP_INDEXED_READ_CMD: begin
                                    mem_addr_q <= ptr_q + 16'h0001;
                                    ptr_q <= ptr_q + 16'h0001;
                                    mem_rd_q <= 1'b1;
                                    st_q <= S_RW;
                                end
                                `OP_INDEXED_WRITE_CMD: st_q <= S_DAT;
                                `OP_STACK_POINTER_READ_CMD: begin
                                    res_q <= STACK_PTR[15:8];
                                    st_q <= S_SEND;
                                end
                                `OP_RUN: run_q <= 1'b1;
                                default: st_q <= S_OP;
                            endcase
                        end
                    end
                    S_AH: begin
                        if (rx_byte_v) begin
                            addr_q[15:8] <= rx_sh_q;
                            st_q <= S_AL;
                        end
                    end
                    S_AL: begin
                        if (rx_byte_v) begin
                            addr_q[7:0] <= rx_sh_q;
                            if (cmd_q == `OP_READ) begin
                                mem_addr_q <= {addr_q[15:8], rx_sh_q};
                                ptr_q <= {addr_q[15:8], rx_sh_q};
                                mem_rd_q <= 1'b1;
                                st_q <= S_RW;
                            end else begin
                                st_q <= S_DAT;
                            end
                        end
                    end
                    S_DAT: begin
                        if (rx_byte_v) begin
                            // Plain write uses the sent address; indexed write uses the next one.
                            mem_addr_q <= (cmd_q == `OP_WRITE) ? addr_q : ptr_q + 16'h0001;
                            ptr_q <= (cmd_q == `OP_WRITE) ? addr_q : ptr_q + 16'h0001;
                            mem_wdata_q <= rx_sh_q;
                            mem_wr_q <= 1'b1;
                            st_q <= S_OP;
                        end
                    end
                    S_SEND: begin
                        if (res_go) begin
                            second_q <= 1'b1;
                            if ((cmd_q == `OP_INDEXED_READ_CMD) && !second_q) begin
                                mem_addr_q <= ptr_q + 16'h0001;
                                ptr_q <= ptr_q + 16'h0001;
                                mem_rd_q <= 1'b1;
                                st_q <= S_RW;
                            end else if ((cmd_q == `OP_STACK_POINTER_READ_CMD) && !second_q) begin
                                res_q <= STACK_PTR[7:0];
                            end else begin
                                st_q <= S_OP;
                            end
                        end
                    end
                    default: st_q <= S_OP;
                endcase
            end
        end
    end

    // Security state survives ordinary resets; only power-on clears it.
    always @(posedge SYS_CLK or negedge POR_N) begin
        if (!POR_N) begin
            sec_q <= `SEC_LOCKED;
        end else if (sec_done && (sec_q == `SEC_LOCKED)) begin
            sec_q <= sec_match ? `SEC_BYPASS : `SEC_FAILED;
        end
    end

    // Divider pin is caught once after release; illegal-address resets come from fetches or a failed part.
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            init_q <= 1'b0;
            div_q <= 1'b0;
            ill_q <= 1'b0;
        end else begin
            init_q <= 1'b1;
            if (!init_q) begin
                div_q <= DIV_SEL;
            end
            ill_q <= (!init_q && (sec_q == `SEC_FAILED)) ||
                     (FETCH_VALID && fetch_in_rom && !bypassed);
        end
    end

endmodule // monitor_command_link

// *** core/monitor_command_link_regs.vh ***
// Constants of the monitor command link: opcodes, security window, bit timing and transmit frames.
// Assumes the includer runs on a 40 ns system clock and that memory is a plain byte-wide array.
//
// Contract
// - Memory write opcode 49, address, data stored
// - Indexed read returns next two bytes, advances
// - Stack pointer read returns two bytes, high first
// - Bit rate from clock, halved when pin high
// - Wait for eight security bytes after reset
// - Compare bytes with FFF6 to FFFD, all match
// - Bypassed security allows ROM read and execute
// - Bypass holds until power-on reset only
// - Other resets need eight bytes sent again
// - Resent bytes ignored once bypass is held
// - Mismatch keeps monitor, ROM reads return undefined
// - Locked ROM fetch causes illegal-address reset
// - Failed attempt makes later resets loop forever
// - Ready break sent only after eight bytes
// - Echo every byte, results after last echo
// - Memory read opcode 4A, address, byte returned
// - Received break: two high bits, then echo
`ifndef MONITOR_COMMAND_LINK_REGS_VH
`define MONITOR_COMMAND_LINK_REGS_VH

// Command opcodes.
`define OP_WRITE 8'h49
`define OP_READ 8'h4A
`define OP_INDEXED_READ_CMD 8'h1A
`define OP_INDEXED_WRITE_CMD 8'h19
`define OP_STACK_POINTER_READ_CMD 8'h0C
`define OP_RUN 8'h28

// Security byte window and ROM range.
`define SEC_BASE 16'hFFF6
`define SEC_LAST_IDX 3'h7
`define ROM_LO 16'h8000
`define ROM_HI 16'hFFFF
`define UNDEF_DATA 8'hFF

// Security states, held across every reset except power-on.
`define SEC_LOCKED 2'h0
`define SEC_BYPASS 2'h1
`define SEC_FAILED 2'h2

// Bit time is 552 crystal periods, 138000 ns with a 4 MHz crystal (about 7246.37 baud).
// At the 40 ns system clock that is 3450 cycles, kept sized so the parameter takes it without truncation.
`define BIT_TIME_NS 138000
`define SYS_PERIOD_NS 40
`define BIT_CYC 14'hD7A

// Transmit frames, bit 0 leaves first; idle fill is high.
`define FRAME_IDLE 12'hFFF
`define FRAME_BRK_ECHO 12'h003
`define FRAME_BRK_READY 12'h000
`define FRAME_LEN_BYTE 4'hA
`define FRAME_LEN_BRK_ECHO 4'hC

`endif

// *** dv/host_model.sv ***
// Host model on the far side of the monitor serial line: sends bytes and collects every device frame.
// Assumes the bench resolves the wired-OR line and supplies the bit time in clock cycles.
`timescale 1ns/1ps

module host_model (
    input wire clk,
    input wire line,
    input wire oe_n,
    input wire [15:0] bt,
    output logic tx
);
    logic [8:0] rxq[$];

    initial tx = 1'b1;

    // Start, eight data bits LSB first, stop; the line is held high afterwards.
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            tx <= f[i];
            repeat (bt) @(posedge clk);
        end
    endtask

    // Break: a start bit and nine more low bits, then the line is let go high for one bit.
    task automatic send_brk;
        tx <= 1'b0;
        repeat (10 * bt) @(posedge clk);
        tx <= 1'b1;
        repeat (bt) @(posedge clk);
    endtask

    // Device frames are sampled mid-bit; our own start bits are ignored since the device is not driving.
    always begin
        @(negedge line);
        if (oe_n === 1'b0) begin
            logic [8:0] v;
            repeat (bt / 2) @(posedge clk);
            for (int i = 0; i < 9; i++) begin
                repeat (bt) @(posedge clk);
                v[i] = line;
            end
            rxq.push_back(v);
        end
    end
endmodule // host_model

// *** dv/monitor_command_link_sva.sv ***
// Checker for the monitor command link, seeing only the top module's ports.
// Assumes one clock domain; frame lengths allow both bit rates.
`timescale 1ns/1ps

module monitor_command_link_sva #(
    parameter [13:0] BIT_CYCLES = 16
) (
    input wire SYS_CLK,
    input wire NRST,
    input wire POR_N,
    input wire SER_OUT,
    input wire SER_OE_N,
    input wire MEM_RD,
    input wire MEM_WR,
    input wire FETCH_VALID,
    input wire [15:0] FETCH_ADDR,
    input wire RUN_RTI,
    input wire ILLEGAL_RST,
    input wire SEC_BYPASSED,
    input wire ROM_EXEC_EN
);
    localparam int B = BIT_CYCLES;
    int low_q;

    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);

    // Counts how long the pin has been driven, so a whole frame can be judged at release.
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) low_q <= 0;
        else if (!SER_OE_N) low_q <= low_q + 1;
        else low_q <= 0;
    end

    a_frame_len: assert property ($rose(SER_OE_N) |-> low_q inside {10*B, 12*B, 20*B, 24*B})
        else $error("drive window of wrong length");
    a_idle_high: assert property (SER_OE_N |-> SER_OUT)
        else $error("serial output not high while released");
    a_rd_pulse: assert property (MEM_RD |=> !MEM_RD)
        else $error("memory read longer than one cycle");
    a_wr_pulse: assert property (MEM_WR |=> !MEM_WR)
        else $error("memory write longer than one cycle");
    a_run_pulse: assert property (RUN_RTI |=> !RUN_RTI)
        else $error("run pulse longer than one cycle");
    a_exec_match: assert property (ROM_EXEC_EN == SEC_BYPASSED)
        else $error("execute enable differs from bypass");
    a_fetch_illegal: assert property (FETCH_VALID && FETCH_ADDR[15] && !SEC_BYPASSED |=> ILLEGAL_RST)
        else $error("locked fetch without illegal reset");
    a_illegal_cause: assert property (ILLEGAL_RST |-> !$past(SEC_BYPASSED))
        else $error("illegal reset while bypassed");
    a_bypass_hold: assert property (disable iff (!POR_N) !$fell(SEC_BYPASSED))
        else $error("bypass lost without power-on");

    c_bypass: cover property ($rose(SEC_BYPASSED));
    c_write: cover property (MEM_WR);
    c_run: cover property (RUN_RTI);
    c_illegal: cover property (ILLEGAL_RST);
endmodule // monitor_command_link_sva

bind monitor_command_link monitor_command_link_sva #(.BIT_CYCLES(BIT_CYCLES)) chk_i (
    .SYS_CLK(SYS_CLK), .NRST(NRST), .POR_N(POR_N), .SER_OUT(SER_OUT), .SER_OE_N(SER_OE_N),
    .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .FETCH_VALID(FETCH_VALID), .FETCH_ADDR(FETCH_ADDR),
    .RUN_RTI(RUN_RTI), .ILLEGAL_RST(ILLEGAL_RST), .SEC_BYPASSED(SEC_BYPASSED), .ROM_EXEC_EN(ROM_EXEC_EN));

// *** dv/tb_top.sv ***
// Self-checking bench for the monitor command link: host model, byte memory and scenario tasks.
// Assumes a shortened bit time of 16 cycles; memory answers one cycle after each read pulse.
`timescale 1ns/1ps

module tb_top;
    logic clk = 0, nrst = 0, por_n = 0, div_sel = 0, fv = 0;
    logic [15:0] fa = 16'h0000, sp = 16'hBEEF, bt = 16'h0010;
    logic [7:0] rdata = 8'h00;
    logic [7:0] mem [0:65535];
    logic [8:0] r [0:1];
    wire line, ser_out, oe_n, rd, wr, return_from_interrupt_instr, ill, byp, xen, host_tx;
    wire [15:0] addr;
    wire [7:0] wdata;
    int failures = 0, n_checks = 0, ill_cnt = 0, rti_cnt = 0;

    always #20 clk = ~clk;
    // The line follows the host's transmit output whenever the device is not driving it.
    assign line = oe_n ? host_tx : ser_out;

    monitor_command_link #(.BIT_CYCLES(14'h0010)) monitor_command_link_i (
        .SYS_CLK(clk), .NRST(nrst), .POR_N(por_n), .DIV_SEL(div_sel), .SER_IN(line), .SER_OUT(ser_out),
        .SER_OE_N(oe_n), .MEM_ADDR(addr), .MEM_RD(rd), .MEM_WR(wr), .MEM_WDATA(wdata), .MEM_RDATA(rdata),
        .STACK_PTR(sp), .FETCH_VALID(fv), .FETCH_ADDR(fa), .RUN_RTI(return_from_interrupt_instr), .ILLEGAL_RST(ill),
        .SEC_BYPASSED(byp), .ROM_EXEC_EN(xen));
    host_model host_model_i (.clk(clk), .line(line), .oe_n(oe_n), .bt(bt), .tx(host_tx));

    // Read data stands one cycle only; afterwards it toggles so a late sample cannot pass.
    always @(posedge clk) begin
        if (wr === 1'b1) mem[addr] <= wdata;
        if (rd === 1'b1) rdata <= mem[addr];
        else rdata <= ~rdata;
        if (ill === 1'b1) ill_cnt++;
        if (return_from_interrupt_instr === 1'b1) rti_cnt++;
    end

    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rst(input bit por);
        nrst <= 1'b0;
        if (por) por_n <= 1'b0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        por_n <= 1'b1;
        @(posedge clk);
    endtask

    // Waits until n frames have come in, then lets the last one finish; a shortfall is a mismatch.
    task automatic collect(input int n);
        int k;
        k = 0;
        while (host_model_i.rxq.size() < n && k < 80 * bt) begin
            @(posedge clk);
            k++;
        end
        repeat (bt) @(posedge clk);
        chk("frames", n, host_model_i.rxq.size());
    endtask

    // Sends one byte, checks its echo and keeps the n results that follow it.
    task automatic xfer(input logic [7:0] b, input int n);
        host_model_i.send(b);
        collect(n + 1);
        chk("echo", {1'b1, b}, host_model_i.rxq.pop_front());
        for (int i = 0; i < n; i++) r[i] = host_model_i.rxq.pop_front();
    endtask

    task automatic sec(input logic [7:0] base);
        for (int i = 0; i < 8; i++) xfer(base + i, i == 7);
        chk("ready break", 9'h000, r[0]);
    endtask

    task automatic t_power;
        rst(1);
        sec(8'hA0);
        chk("bypass", 9'h001, {8'h00, byp});
        chk("rom exec", 9'h001, {8'h00, xen});
        $display("test power done");
    endtask

    task automatic t_cmds;
        int c;
        c = rti_cnt;
        xfer(8'h49, 0); xfer(8'h12, 0); xfer(8'h34, 0); xfer(8'h5A, 0);
        chk("mem 1234", 9'h05A, {1'b0, mem[16'h1234]});
        xfer(8'h4A, 0); xfer(8'h12, 0); xfer(8'h34, 1);
        chk("read", 9'h15A, r[0]);
        xfer(8'h1A, 2);
        chk("indexed_read_cmd 1", 9'h111, r[0]);
        chk("indexed_read_cmd 2", 9'h122, r[1]);
        xfer(8'h19, 0);
        xfer(8'h77, 0);
        chk("indexed_write_cmd", 9'h077, {1'b0, mem[16'h1237]});
        // A break after the high address byte drops the read, so the next byte must be taken as a command.
        xfer(8'h4A, 0);
        xfer(8'h12, 0);
        host_model_i.send_brk();
        collect(1);
        chk("break echo", 9'h000, host_model_i.rxq.pop_front());
        xfer(8'h0C, 2);
        chk("sp high", 9'h1BE, r[0]);
        chk("sp low", 9'h1EF, r[1]);
        xfer(8'h4A, 0); xfer(8'h80, 0); xfer(8'h00, 1);
        chk("rom read", 9'h13C, r[0]);
        xfer(8'h28, 0);
        chk("run", 9'h001, rti_cnt - c);
        $display("test commands done");
    endtask

    task automatic t_warm;
        rst(0);
        sec(8'h00);
        chk("bypass kept", 9'h001, {8'h00, byp});
        $display("test warm reset done");
    endtask

    task automatic t_fail;
        int c;
        rst(1);
        sec(8'h00);
        chk("locked", 9'h000, {8'h00, byp});
        xfer(8'h4A, 0); xfer(8'h80, 0); xfer(8'h00, 1);
        chk("rom undefined", 9'h1FF, r[0]);
        c = ill_cnt;
        fa <= 16'h9000;
        fv <= 1'b1;
        @(posedge clk);
        fv <= 1'b0;
        repeat (3) @(posedge clk);
        chk("fetch reset", 9'h001, ill_cnt - c);
        c = ill_cnt;
        div_sel <= 1'b1;
        bt <= 16'h0020;
        rst(0);
        repeat (3) @(posedge clk);
        chk("reset loop", 9'h001, ill_cnt - c);
        xfer(8'h55, 0);
        $display("test failed security done");
    endtask

    task automatic conclude;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Mask a fixed run pattern into memory: security bytes, indexed data and one ROM byte.
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
        for (int i = 0; i < 8; i++) mem[16'hFFF6 + i] = 8'hA0 + i;
        mem[16'h1235] = 8'h11;
        mem[16'h1236] = 8'h22;
        mem[16'h8000] = 8'h3C;
        t_power();
        t_cmds();
        t_warm();
        t_fail();
        conclude();
    end

    // A hang is cut short well past the expected run of about 17000 cycles.
    initial begin
        repeat (80000) @(posedge clk);
        failures++;
        conclude();
    end
endmodule // tb_top
